// ---- design/smst_pkg.sv ----
package smst_pkg;
  // Register byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_BAUD = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_TXD = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h10;
  // Control register fields
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_SPE = 1;
  localparam int CTRL_CSM = 2;
  localparam int CTRL_SRE = 3;
  localparam int CTRL_CRE = 4;
  localparam int CTRL_TXE = 5;
  localparam int CTRL_NINE = 6;
  localparam int CTRL_BIT9 = 7;
  localparam int CTRL_POL = 8;
  localparam int CTRL_HS = 9;
  localparam int CTRL_WIDE = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Status and mask fields
  localparam int EV_W = 2;
  localparam int EV_HOLD_EMPTY = 0;
  localparam int EV_CHAR_DONE = 1;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;
  localparam int STAT_HOLD_FULL = 8;
  localparam int STAT_BUSY = 9;
  localparam int STAT_DT_PIN = 10;
  localparam int STAT_CK_PIN = 11;
  // Character lengths
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  // Prescale limits for the baud counter
  localparam logic [1:0] PRE_HS = 2'h0;
  localparam logic [1:0] PRE_LS = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Shift engine states
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} smst_state_t;
endpackage : smst_pkg

// ---- design/smst_baud_gen.sv ----
`timescale 1ns/1ps
module smst_baud_gen
  import smst_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic high_speed,
  output logic tick
);
  logic [1:0] pre_q;
  logic [DIV_W-1:0] cnt_q;
  logic tick_q;

  // Prescale wrap and divisor wrap
  wire [1:0] pre_lim = high_speed ? PRE_HS : PRE_LS;
  wire pre_wrap = (pre_q == pre_lim);
  wire cnt_wrap = pre_wrap && (cnt_q == divisor);

  // Half-bit enable pulse, restarted on each character load
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      pre_q <= 2'h0;
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_wrap ? 2'h0 : pre_q + 2'h1;
      if (pre_wrap)
        cnt_q <= cnt_wrap ? '0 : cnt_q + 1'b1;
      tick_q <= cnt_wrap;
    end
  end

  assign tick = tick_q;
endmodule : smst_baud_gen

// ---- design/smst_top.sv ----
`timescale 1ns/1ps
// What this block does
// RULE1 - Data leaves on the data pin only
// RULE2 - Both pin drivers enable automatically in mode
// RULE3 - Only a holding register write starts sending
// RULE4 - New character waits while shifter still busy
// RULE5 - Empty shifter loads holding register at once
// RULE6 - Shifting starts right after the load
// RULE7 - Data changes on leading edge, held until next
// RULE8 - Shift register has no bus address
// RULE9 - Software sets divisor and speed bits first
// RULE10 - Software sets sync, enable and master bits
// RULE11 - Software clears both receive enables
// RULE12 - Software sets transmit enable before data
// RULE13 - Nine-bit mode shifts nine bits per character
// RULE14 - Software enables transmit interrupt if wanted
// RULE15 - Device drives shift clock on clock pin
// RULE16 - Exactly one clock cycle per data bit
// RULE17 - Polarity bit picks clock idle level
// RULE18 - No start or stop bits are framed
// RULE19 - Holding-empty flag raised on each transfer
module smst_top
  import smst_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_n,
  input wire logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe_n,
  output logic irq
);
  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [ADDR_W-1:0] awaddr_q;
  // Registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] baud_q;
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [EV_W-1:0] sts_q, mask_q;
  logic irq_q;
  // Shift engine
  smst_state_t st_q;
  logic [8:0] shreg_q;
  logic [3:0] left_q;
  logic ck_act_q, ck_out_q, dt_out_q, dt_oe_n_q, ck_oe_n_q;
  logic [1:0] pin_s1_q, pin_s2_q;
  logic tick;

  // Byte-lane mask from write strobes
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Write decode, once address and data are both held
  wire wr_go = !awready_q && !wready_q && !bvalid_q;
  wire wr_ctrl = wr_go && (awaddr_q == ADDR_CTRL);
  wire wr_baud = wr_go && (awaddr_q == ADDR_BAUD);
  wire wr_txd = wr_go && (awaddr_q == ADDR_TXD) && wstrb_q[0];
  wire wr_stat = wr_go && (awaddr_q == ADDR_STAT);
  wire wr_mask = wr_go && (awaddr_q == ADDR_MASK);
  wire wr_hit = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_BAUD) ||
                (awaddr_q == ADDR_TXD) || (awaddr_q == ADDR_STAT) ||
                (awaddr_q == ADDR_MASK);

  // Mode decode and configuration fields
  wire sync_master = ctrl_q[CTRL_SYNC] && ctrl_q[CTRL_SPE] &&
                     ctrl_q[CTRL_CSM];
  wire mode_ok = sync_master && ctrl_q[CTRL_TXE] &&
                 !ctrl_q[CTRL_SRE] && !ctrl_q[CTRL_CRE];
  wire pol = ctrl_q[CTRL_POL];
  wire [DIV_W-1:0] divisor = ctrl_q[CTRL_WIDE] ?
                             DIV_W'(baud_q) : DIV_W'(baud_q[7:0]);

  // Engine strobes
  wire lead_w = (st_q == ST_LEAD) && tick;
  wire trail_w = (st_q == ST_TRAIL) && tick;
  wire last_w = trail_w && (left_q == 4'h1);
  wire busy_w = (st_q != ST_IDLE);
  wire xfer_w = mode_ok && hold_full_q && (!busy_w || last_w); // RULE5
  wire [3:0] nbits = ctrl_q[CTRL_NINE] ? BITS_9 : BITS_8; // RULE13
  wire ck_act_d = mode_ok && (lead_w || (ck_act_q && !trail_w));

  // Read decode; the shift register is never on the map
  wire ar_hs = s_axi_arvalid && arready_q;
  wire rd_ctrl = (s_axi_araddr == ADDR_CTRL);
  wire rd_baud = (s_axi_araddr == ADDR_BAUD);
  wire rd_txd = (s_axi_araddr == ADDR_TXD);
  wire rd_stat = (s_axi_araddr == ADDR_STAT);
  wire rd_mask = (s_axi_araddr == ADDR_MASK);
  wire rd_hit = rd_ctrl || rd_baud || rd_txd || rd_stat || rd_mask; // RULE8
  wire [31:0] stat_word = {20'h0, pin_s2_q[1], pin_s2_q[0], busy_w,
                           hold_full_q, 6'h0, sts_q};
  wire [31:0] rd_word =
    rd_ctrl ? {21'h0, ctrl_q} :
    rd_baud ? {16'h0, baud_q} :
    rd_stat ? stat_word :
    rd_mask ? {30'h0, mask_q} : 32'h0;

  // Sticky events, set wins over write-one-clear
  wire [EV_W-1:0] ev = {last_w, xfer_w}; // RULE19
  wire [EV_W-1:0] w1c = wr_stat ? wdata_q[EV_W-1:0] & wmask[EV_W-1:0]
                                : '0;
  wire [EV_W-1:0] sts_d = (sts_q & ~w1c) | ev;

  smst_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(xfer_w || !busy_w),
    .divisor(divisor),
    .high_speed(ctrl_q[CTRL_HS]),
    .tick(tick)
  );

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Configuration, baud divisor, status and mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      mask_q <= EV_RST;
      sts_q <= EV_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~wmask[CTRL_W-1:0]) |
                  (wdata_q[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
      if (wr_baud)
        baud_q <= (baud_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
      if (wr_mask)
        mask_q <= (mask_q & ~wmask[EV_W-1:0]) |
                  (wdata_q[EV_W-1:0] & wmask[EV_W-1:0]);
      sts_q <= sts_d;
      irq_q <= |(sts_q & mask_q);
    end
  end

  // Holding register, new write wins over a same-cycle transfer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end
    else if (wr_txd)
    begin
      hold_q <= wdata_q[7:0]; // RULE3
      hold_full_q <= 1'b1; // RULE3
    end
    else if (xfer_w)
      hold_full_q <= 1'b0; // RULE4
  end

  // Shift engine: load, leading edge, trailing edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      shreg_q <= 9'h000;
      left_q <= 4'h0;
      ck_act_q <= 1'b0;
      dt_out_q <= 1'b0;
    end
    else
    begin
      ck_act_q <= ck_act_d;
      if (!mode_ok)
        st_q <= ST_IDLE;
      else if (xfer_w)
      begin
        shreg_q <= {ctrl_q[CTRL_BIT9], hold_q}; // RULE13
        left_q <= nbits; // RULE18
        st_q <= ST_LEAD; // RULE6
      end
      else if (lead_w)
      begin
        dt_out_q <= shreg_q[0]; // RULE7
        shreg_q <= {1'b0, shreg_q[8:1]};
        st_q <= ST_TRAIL;
      end
      else if (trail_w)
      begin
        left_q <= left_q - 4'h1; // RULE16
        st_q <= last_w ? ST_IDLE : ST_LEAD;
      end
    end
  end

  // Pin drivers and pin readback synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_out_q <= 1'b0;
      dt_oe_n_q <= 1'b1;
      ck_oe_n_q <= 1'b1;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end
    else
    begin
      ck_out_q <= pol ^ ck_act_d; // RULE17
      dt_oe_n_q <= !mode_ok; // RULE2
      ck_oe_n_q <= !sync_master; // RULE15
      pin_s1_q <= {shift_clock_pin_in, serial_data_pin_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign serial_data_pin_out = dt_out_q; // RULE1
  assign serial_data_pin_oe_n = dt_oe_n_q;
  assign shift_clock_pin_out = ck_out_q; // RULE15
  assign shift_clock_pin_oe_n = ck_oe_n_q;
  assign irq = irq_q;

  // Checker helpers: leading edges per character
  logic [3:0] lead_cnt_q, char_bits_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lead_cnt_q <= 4'h0;
      char_bits_q <= 4'h0;
    end
    else if (xfer_w)
    begin
      lead_cnt_q <= 4'h0;
      char_bits_q <= nbits;
    end
    else if (lead_w)
      lead_cnt_q <= lead_cnt_q + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Load followed by entry to the leading-edge state
  sequence s_load;
    xfer_w ##1 (st_q == ST_LEAD);
  endsequence
  sequence s_flag;
    sts_q[EV_HOLD_EMPTY] ##1 1'b1;
  endsequence

  property p_start_needs_write;
    $rose(busy_w) |-> $past(hold_full_q) && $past(mode_ok);
  endproperty
  a_start_needs_write: assert property (p_start_needs_write) // RULE3
    else $error("shift started without a held character");

  property p_hold_waits;
    hold_full_q && busy_w && !last_w && !wr_txd |=> hold_full_q;
  endproperty
  a_hold_waits: assert property (p_hold_waits) // RULE4
    else $error("held character lost while shifter busy");

  property p_load_now;
    mode_ok && hold_full_q && !busy_w && !wr_txd |-> s_load;
  endproperty
  a_load_now: assert property (p_load_now) // RULE5
    else $error("idle shifter did not load at once");

  property p_data_steady;
    busy_w && !lead_w ##1 busy_w |-> $stable(dt_out_q);
  endproperty
  a_data_steady: assert property (p_data_steady) // RULE7
    else $error("data changed away from a leading edge");

  property p_edges_per_char;
    $fell(busy_w) && $past(mode_ok) |-> lead_cnt_q == char_bits_q;
  endproperty
  a_edges_per_char: assert property (p_edges_per_char) // RULE16
    else $error("clock cycles differ from data bits");

  property p_idle_level;
    !busy_w ##1 !busy_w |=> ck_out_q == $past(pol);
  endproperty
  a_idle_level: assert property (p_idle_level) // RULE17
    else $error("clock not at its idle level");

  property p_drivers_on;
    mode_ok ##1 mode_ok |-> !dt_oe_n_q && !ck_oe_n_q;
  endproperty
  a_drivers_on: assert property (p_drivers_on) // RULE2
    else $error("pin drivers not enabled in transmit mode");

  property p_flag_irq;
    xfer_w && mask_q[EV_HOLD_EMPTY] ##1 !wr_stat |-> s_flag ##0 irq_q;
  endproperty
  a_flag_irq: assert property (p_flag_irq) // RULE19
    else $error("holding-empty flag or interrupt missing");

  property p_unmapped;
    ar_hs && !rd_hit |=> rvalid_q && rresp_q == RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE8
    else $error("unmapped read not refused");
endmodule : smst_top

// ---- tb/smst_slave_model.sv ----
`timescale 1ns/1ps
module smst_slave_model (
  input wire logic aclk,
  input wire logic pol,
  input wire logic [3:0] nbits,
  input wire logic dt_out,
  input wire logic dt_oe_n,
  input wire logic ck_out,
  input wire logic ck_oe_n,
  output logic dt_level,
  output logic ck_level,
  output logic [8:0] rx_word,
  output logic [31:0] rx_words,
  output logic [31:0] lead_edges
);
  logic dt_last_q = 1'b0;
  logic ck_last_q = 1'b0;
  logic ck_prev_q = 1'b0;
  logic ck_drv_q = 1'b0;
  logic [8:0] sh_q = 9'h000;
  logic [3:0] cnt_q = 4'h0;
  logic [8:0] sh_nxt;
  initial rx_word = 9'h000;
  initial rx_words = 32'h0;
  initial lead_edges = 32'h0;
  // Released lines show the inverse of their last driven level
  assign dt_level = dt_oe_n ? ~dt_last_q : dt_out;
  assign ck_level = ck_oe_n ? ~ck_last_q : ck_out;
  assign sh_nxt = {dt_level, sh_q[8:1]};
  // Slave shifter: edges only count while the clock is driven
  always @(posedge aclk)
  begin
    if (!dt_oe_n) dt_last_q <= dt_out;
    if (!ck_oe_n) ck_last_q <= ck_out;
    ck_prev_q <= ck_level;
    ck_drv_q <= !ck_oe_n;
    if (ck_oe_n) cnt_q <= 4'h0;
    else if (ck_drv_q && ck_level != ck_prev_q)
    begin
      // Sample on the trailing edge, LSB first
      if (ck_level == pol)
      begin
        sh_q <= sh_nxt;
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q + 4'h1 == nbits)
        begin
          rx_word <= sh_nxt >> (4'h9 - nbits);
          rx_words <= rx_words + 32'h1;
          cnt_q <= 4'h0;
        end
      end
      else lead_edges <= lead_edges + 32'h1;
    end
  end
endmodule : smst_slave_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import smst_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, l0, rx_words, leads;
  logic serial_data_pin_out, serial_data_pin_oe_n, shift_clock_pin_out;
  logic shift_clock_pin_oe_n, irq, dt_lvl, ck_lvl;
  logic pol = 1'b0;
  logic [3:0] nbits = BITS_8;
  logic [8:0] rx_word;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc;
  smst_top u_smst_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_data_pin_in(dt_lvl), .serial_data_pin_out,
    .serial_data_pin_oe_n, .shift_clock_pin_in(ck_lvl),
    .shift_clock_pin_out, .shift_clock_pin_oe_n, .irq);
  smst_slave_model u_smst_slave_model (.aclk, .pol, .nbits,
    .dt_out(serial_data_pin_out), .dt_oe_n(serial_data_pin_oe_n),
    .ck_out(shift_clock_pin_out), .ck_oe_n(shift_clock_pin_oe_n),
    .dt_level(dt_lvl), .ck_level(ck_lvl), .rx_word, .rx_words,
    .lead_edges(leads));
  // 100 MHz system clock
  always #5 aclk = ~aclk;
  task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // Register write; each channel released once taken
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready)
      || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Register read
  task rdr(input logic [ADDR_W-1:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  // Wait for the slave to complete one character
  task wait_word;
    l0 = rx_words;
    cyc = 0;
    while (rx_words == l0)
    begin
      @(posedge aclk);
      cyc++;
    end
  endtask : wait_word
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ADDR_CTRL);
    chk(rd, 32'h0, "ctrl reset");
    rdr(ADDR_BAUD);
    chk(rd, 32'h0, "baud reset");
    rdr(ADDR_MASK);
    chk(rd, 32'h0, "mask reset");
    rdr(ADDR_STAT);
    chk(rd & 32'h3ff, 32'h0, "stat reset");
    chk({29'h0, serial_data_pin_oe_n, shift_clock_pin_oe_n, irq},
      32'h6, "pins after reset");
    rdr(ADDR_TXD);
    chk(rd, 32'h0, "holding reads zero");
    rdr(5'h14);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(5'h14, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    // Divisor 3 at high speed: 80 ns shift clock
    wr(ADDR_BAUD, 32'h3);
    wr(ADDR_CTRL, 32'h227);
    repeat (100) @(posedge aclk);
    chk({29'h0, serial_data_pin_oe_n, shift_clock_pin_oe_n,
      shift_clock_pin_out}, 32'h0, "drivers on, idle low");
    chk(rx_words + leads, 32'h0, "no clock without write");
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_TXD, 32'ha5);
    wait_word;
    chk({23'h0, rx_word}, 32'ha5, "first char");
    chk(leads, 32'h8, "clock count");
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq on empty");
    rdr(ADDR_STAT);
    chk(rd & 32'h3, 32'h3, "events set");
    wr(ADDR_STAT, 32'h3);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Back-to-back characters
    wr(ADDR_TXD, 32'h3c);
    wr(ADDR_TXD, 32'hc3);
    rdr(ADDR_STAT);
    chk(rd & 32'h100, 32'h100, "second char held");
    wait_word;
    chk({23'h0, rx_word}, 32'h3c, "char one");
    wait_word;
    chk({23'h0, rx_word}, 32'hc3, "char two");
    chk({31'h0, cyc <= 65}, 32'h1, "no gap between chars");
    chk(leads, 32'd24, "clock count b2b");
    // Nine bits, clock idle high
    wr(ADDR_CTRL, 32'h0);
    pol <= 1'b1;
    nbits <= BITS_9;
    wr(ADDR_CTRL, 32'h3e7);
    repeat (10) @(posedge aclk);
    chk({31'h0, shift_clock_pin_out}, 32'h1, "idle high");
    wr(ADDR_TXD, 32'h5a);
    wait_word;
    chk({23'h0, rx_word}, 32'h15a, "nine-bit char");
    chk(leads, 32'd33, "nine clocks");
    rdr(ADDR_STAT);
    chk(rd & 32'hc00, 32'hc00, "pins idle high, ninth bit");
    wr(ADDR_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    // Abort in mid-character
    l0 = rx_words;
    wr(ADDR_TXD, 32'hff);
    repeat (20) @(posedge aclk);
    wr(ADDR_CTRL, 32'h0);
    repeat (200) @(posedge aclk);
    chk(rx_words, l0, "aborted char");
    chk({31'h0, serial_data_pin_oe_n}, 32'h1, "driver off");
    results();
  end
endmodule : testbench
